/* File: hw/sar_pkg.sv */
package sar_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Word format
  localparam int DATA_W = 16;
  localparam logic [4:0] BIT_CNT_DONE = 5'h10;  // Bits in one device word

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_SYS_NS    = 10;    // Period of clk_sys
  localparam int T_CONV_NS     = 1000;  // Internal conversion time
  localparam int T_CONV_MAX_NS = 1500;  // Longest conversion the host allows for
  localparam int T_SEL_NS      = 80;    // Host wait from select to first clock
  localparam logic [15:0] CONV_CYC     = 16'((T_CONV_NS + CLK_SYS_NS - 1) / CLK_SYS_NS);
  localparam logic [15:0] CONV_MAX_CYC = 16'((T_CONV_MAX_NS + CLK_SYS_NS - 1) / CLK_SYS_NS);
  localparam logic [15:0] SEL_CYC      = 16'((T_SEL_NS + CLK_SYS_NS - 1) / CLK_SYS_NS);
  localparam logic [3:0]  SCLK_HALF    = 4'h4;  // Half link period in clk_sys cycles

  ////////////////////////////////////////////////////////////////////////
  // Modes and states
  typedef enum logic [1:0] {
    SAR_MODE_3W    = 2'h0,
    SAR_MODE_4W    = 2'h1,
    SAR_MODE_DAISY = 2'h2
  } sar_mode_e;

  typedef enum logic [2:0] {
    SAR_DEV_IDLE = 3'b001,
    SAR_DEV_CONV = 3'b010,
    SAR_DEV_ACQ  = 3'b100
  } sar_dev_st_e;

  typedef enum logic [4:0] {
    SAR_HST_IDLE  = 5'b00001,
    SAR_HST_CONV  = 5'b00010,
    SAR_HST_SEL   = 5'b00100,
    SAR_HST_SHIFT = 5'b01000,
    SAR_HST_END   = 5'b10000
  } sar_hst_st_e;

endpackage

/* File: hw/sar_if.sv */
interface sar_if;

  // Pins driven by the host
  logic conversion_start_pin;
  logic din;
  logic sclk;
  // Data-out pin as driven by the device
  logic dout_o;
  logic dout_oe_n;
  // Resolved line, pulled high while released
  logic dout_line;

  assign dout_line = dout_oe_n ? 1'b1 : dout_o;

  modport dev (
    input  conversion_start_pin,
    input  din,
    input  sclk,
    output dout_o,
    output dout_oe_n
  );

  modport host (
    output conversion_start_pin,
    output din,
    output sclk,
    input  dout_line
  );

endinterface

/* File: hw/sar_sync.sv */
module sar_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // Two flip-flop level synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

/* File: hw/sar_dev.sv */
// Summary of operation
// R1: Start edge with data-in low selects daisy
// R2: Start edge with data-in high selects select
// R3: 3-wire start releases output, samples, converts
// R4: Internal clock conversion always runs to completion
// R5: Host restores start before minimum conversion time (host drops it only after T_CONV_MAX_NS, past the conversion)
// R6: After conversion power down, keep result
// R7: 3-wire start fall drives MSB out
// R8: Lower bits on falls, release after 16
// R9: Bits stable across both clock edges
// R10: 4-wire: start high until all read
// R11: Host restores data-in before minimum time
// R12: 4-wire data-in fall drives MSB, release
// R13: Next select only after previous released
// R14: Never hold start and data-in low (host holds both low in idle while mode is daisy, and after a daisy read)
// R15: Both low drives data-out low
// R16: Daisy: start high until chain read
// R17: Daisy: clock low at start edge
// R18: Daisy: load result, drive MSB immediately
// R19: Daisy: each fall shifts data-in through
// R20: Host gives 16 x N falls, last first
// R21: Power down after conversion, up at start
// R22: Conversion time independent of link clock
// R23: Result is two's complement word
// R24: Link clock only reads, never converts
module sar_dev
  import sar_pkg::*;
#(
  parameter logic [15:0] T_CONV_CYC = sar_pkg::CONV_CYC
) (
  // System clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          resetn,
  // Link pins
  sar_if.dev                                 link,
  // Analog front end stand-in
  input  wire logic signed [sar_pkg::DATA_W-1:0] sample_code,
  // Status
  output logic signed      [sar_pkg::DATA_W-1:0] result,
  output logic                               power_up,
  output logic                               mode_daisy,
  output logic                               eoc
);

  import sar_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  sar_dev_st_e                state;
  logic        [15:0]         timer;
  logic signed [DATA_W-1:0]   held;
  logic                       cv_s;
  logic                       dn_s;
  logic                       cv_q;
  logic                       dn_q;
  logic                       cv_rise;
  logic                       cnt16;
  logic                       cnt16_s;
  logic                       clr;
  logic                       link_rst_n;
  logic                       force_low;
  logic                       oe_n;
  logic                       selected;
  logic        [4:0]          cnt;
  logic        [DATA_W-1:0]   chain;
  logic        [3:0]          bit_idx;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Start and data-in pins cross into the conversion domain
  sar_sync #(
    .W (2)
  ) u_pin_sync (
    .clk   (clk_sys),
    .rst_n (resetn),
    .d     ({link.conversion_start_pin, link.din}),
    .q     ({cv_s, dn_s})
  );

  // End-of-word flag crosses from the link domain
  sar_sync #(
    .W (1)
  ) u_cnt_sync (
    .clk   (clk_sys),
    .rst_n (resetn),
    .d     (cnt16),
    .q     (cnt16_s)
  );

  // One more stage so the edge compares two settled samples
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cv_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      cv_q <= cv_s;
      dn_q <= dn_s;
    end
  end

  // Start edge; data-in is taken from the sample before the edge,
  // so a data-in pin tied to the start pin still reads low
  assign cv_rise = cv_s & ~cv_q;

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  // Edges while converting are ignored; timing comes from clk_sys only
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= SAR_DEV_IDLE;
      timer <= 16'h0000;
    end else begin
      unique case (state)
        SAR_DEV_IDLE, SAR_DEV_ACQ: begin
          timer <= 16'h0000;
          if (cv_rise) begin
            state <= SAR_DEV_CONV;  // R3
          end
        end
        SAR_DEV_CONV: begin
          if (timer == T_CONV_CYC - 16'h0001) begin
            state <= SAR_DEV_ACQ;  // R6
          end else begin
            timer <= timer + 16'h0001;  // R4 R22 R24
          end
        end
      endcase
    end
  end

  // Interface option chosen at every accepted start edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_daisy <= 1'b0;
    end else if (cv_rise && state != SAR_DEV_CONV) begin
      mode_daisy <= ~dn_q;  // R1 R2
    end
  end

  // Input sampled at start, published as a signed word at the end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      held   <= '0;
      result <= '0;
      eoc    <= 1'b0;
    end else begin
      eoc <= 1'b0;
      if (cv_rise && state != SAR_DEV_CONV) begin
        held <= sample_code;  // R3
      end
      if (state == SAR_DEV_CONV && timer == T_CONV_CYC - 16'h0001) begin
        result <= held;  // R18 R23
        eoc    <= 1'b1;
      end
    end
  end

  // Analog core powered only while converting
  assign power_up = state[1];  // R21

  ////////////////////////////////////////////////////////////////////////
  // Output control

  // Select modes: chip select active while either pin is low
  assign selected = ~(cv_s & dn_s);

  // Clear of the link counter: during conversion, and while
  // deselected in select mode so a shared clock cannot advance it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      clr <= 1'b1;
    end else begin
      clr <= cv_rise | (state == SAR_DEV_CONV) | (~mode_daisy & ~selected);
    end
  end

  // Output enable and forced-low drive
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      force_low <= 1'b0;
      oe_n      <= 1'b1;
    end else begin
      force_low <= ~cv_s & ~dn_s;  // R15
      if (!cv_s && !dn_s) begin
        oe_n <= 1'b0;  // R15
      end else if (state != SAR_DEV_ACQ || cv_rise) begin
        oe_n <= 1'b1;  // R3
      end else if (mode_daisy) begin
        oe_n <= 1'b0;  // R18
      end else begin
        oe_n <= ~selected | cnt16_s;  // R7 R8 R12
      end
    end
  end

  assign link.dout_oe_n = oe_n;

  ////////////////////////////////////////////////////////////////////////
  // Link domain, clocked by falling edges of the serial clock

  assign link_rst_n = resetn & ~clr;

  // Bit counter, stops after one word
  always_ff @(negedge link.sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt <= 5'h00;
    end else if (cnt != BIT_CNT_DONE) begin
      cnt <= cnt + 5'h01;  // R8 R12
    end
  end

  // Data-in delay line: after the own word it carries upstream data
  always_ff @(negedge link.sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      chain <= '0;
    end else begin
      chain <= {chain[DATA_W-2:0], link.din};  // R19
    end
  end

  assign cnt16 = (cnt == BIT_CNT_DONE);

  // Bit changes only just after a fall, so it holds over both edges
  assign bit_idx = 4'hf - cnt[3:0];
  assign link.dout_o = force_low ? 1'b0 :
                       cnt16     ? chain[DATA_W-1] :
                                   result[bit_idx];  // R9 R18 R19

endmodule

/* File: hw/sar_host.sv */
module sar_host
  import sar_pkg::*;
#(
  parameter int CHAIN_W = 8
) (
  // System clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          resetn,
  // Link pins
  sar_if.host                                link,
  // User request
  input  wire logic                          start,
  input  wire sar_pkg::sar_mode_e            mode,
  input  wire logic [CHAIN_W-1:0]            chain_len,
  // User answer
  output logic                               busy,
  output logic      [sar_pkg::DATA_W-1:0]    word,
  output logic                               word_valid
);

  import sar_pkg::*;

  sar_hst_st_e          state;
  sar_mode_e            mode_q;
  logic [15:0]          timer;
  logic [3:0]           ph;
  logic [CHAIN_W+3:0]   bitn;
  logic [CHAIN_W+3:0]   total;
  logic [DATA_W-1:0]    shreg;
  logic                 dout_s;

  ////////////////////////////////////////////////////////////////////////
  // Data-out synchroniser
  sar_sync #(
    .W (1)
  ) u_dout_sync (
    .clk   (clk_sys),
    .rst_n (resetn),
    .d     (link.dout_line),
    .q     (dout_s)
  );

  // Select modes read one word; a chain reads one word per device
  assign total = (mode_q == SAR_MODE_DAISY) ? {chain_len, 4'h0} : {{(CHAIN_W-1){1'b0}}, BIT_CNT_DONE};  // R20
  assign busy  = (state != SAR_HST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer driving the pins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state       <= SAR_HST_IDLE;
      mode_q      <= SAR_MODE_3W;
      timer       <= 16'h0000;
      ph          <= 4'h0;
      bitn        <= '0;
      link.conversion_start_pin <= 1'b0;
      link.din    <= 1'b1;
      link.sclk   <= 1'b0;
    end else begin
      unique case (state)
        SAR_HST_IDLE: begin
          link.din  <= (mode != SAR_MODE_DAISY);  // R1 R2
          link.sclk <= 1'b0;  // R17
          timer     <= 16'h0000;
          bitn      <= '0;
          ph        <= 4'h0;
          if (start) begin
            mode_q      <= mode;
            link.conversion_start_pin <= 1'b1;
            state       <= SAR_HST_CONV;
          end
        end
        SAR_HST_CONV: begin
          // Start held high through the whole conversion; data-in held high, or low in daisy
          if (timer == CONV_MAX_CYC) begin
            timer <= 16'h0000;
            state <= SAR_HST_SEL;
            if (mode_q == SAR_MODE_3W) begin
              link.conversion_start_pin <= 1'b0;  // R5 R7
            end else if (mode_q == SAR_MODE_4W) begin
              link.din <= 1'b0;  // R10 R11 R13 R14
            end
          end else begin
            timer <= timer + 16'h0001;
          end
        end
        SAR_HST_SEL: begin
          if (timer == SEL_CYC) begin
            state <= SAR_HST_SHIFT;
          end else begin
            timer <= timer + 16'h0001;
          end
        end
        SAR_HST_SHIFT: begin
          ph <= ph + 4'h1;
          if (ph == 4'h0) begin
            link.sclk <= 1'b1;
          end
          if (ph == SCLK_HALF) begin
            link.sclk <= 1'b0;
            bitn      <= bitn + {{(CHAIN_W+3){1'b0}}, 1'b1};
          end
          if (ph == SCLK_HALF + SCLK_HALF - 4'h1) begin
            ph <= 4'h0;
            if (bitn == total) begin
              state <= SAR_HST_END;  // R20
            end
          end
        end
        SAR_HST_END: begin
          // Deselect without ever holding both pins low in 4-wire
          link.din    <= (mode_q != SAR_MODE_DAISY);  // R14 R16
          link.conversion_start_pin <= 1'b0;
          state       <= SAR_HST_IDLE;
        end
        default: begin
          state <= SAR_HST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture just before each fall, when the bit has settled
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shreg      <= '0;
      word       <= '0;
      word_valid <= 1'b0;
    end else begin
      word_valid <= 1'b0;
      if (state == SAR_HST_SHIFT && ph == SCLK_HALF) begin
        shreg <= {shreg[DATA_W-2:0], dout_s};  // R9
        if (bitn[3:0] == 4'hf) begin
          word       <= {shreg[DATA_W-2:0], dout_s};  // R20
          word_valid <= 1'b1;
        end
      end
    end
  end

endmodule

/* File: testbench/sar_link_monitor.sv */
module sar_link_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Link pins
  input wire logic conversion_start_pin,
  input wire logic din,
  input wire logic sclk,
  input wire logic dout_o,
  input wire logic dout_oe_n,
  input wire logic dout_line
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////
  // Helper state
  logic       sclk_q;
  logic [4:0] fall_cnt;

  // Previous link clock level
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  // Falls counted while the start pin acts as select; saturates
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fall_cnt <= 5'h00;
    end else if (conversion_start_pin) begin
      fall_cnt <= 5'h00;
    end else if (sclk_q && !sclk && fall_cnt != 5'h1f) begin
      fall_cnt <= fall_cnt + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_both_low_drive: assert property ((!conversion_start_pin && !din) [*5] |-> !dout_oe_n && !dout_o)
    else $error("data-out not driven low with both pins low");
  a_sclk_low_start: assert property ($rose(conversion_start_pin) |-> !sclk)
    else $error("link clock high at start edge");
  a_conv_quiet: assert property ($rose(conversion_start_pin) |-> ##6 dout_oe_n [*8] ##80 dout_oe_n)
    else $error("data-out driven during conversion");
  a_daisy_msb: assert property ($rose(conversion_start_pin) && !din |-> ##[100:112] !dout_oe_n)
    else $error("daisy word not presented after conversion");
  a_select_msb: assert property ($fell(din) && conversion_start_pin |-> ##[1:5] !dout_oe_n)
    else $error("data-out not enabled on select");
  a_deselect_release: assert property ($rose(din) |-> ##[1:6] dout_oe_n)
    else $error("data-out not released on deselect");
  a_word_release: assert property (fall_cnt == 5'h10 && !conversion_start_pin |-> ##[0:6] dout_oe_n)
    else $error("data-out not released after last bit");
  a_bit_stable: assert property (sclk && !dout_oe_n && !$past(dout_oe_n) |-> $stable(dout_line))
    else $error("data bit changed while link clock high");
  a_start_held: assert property (sclk && !din |-> conversion_start_pin)
    else $error("start pin low while reading in 4-wire or daisy");

  // Main scenarios
  c_select_start: cover property ($rose(conversion_start_pin) && din);
  c_daisy_start: cover property ($rose(conversion_start_pin) && !din);
  c_four_wire_read: cover property ($fell(din) && conversion_start_pin);

endmodule

/* File: testbench/sar_adc_serial_readout_tb.sv */
module sar_adc_serial_readout_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sar_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Signals
  logic                        clk_sys;
  logic                        resetn;
  logic                        start;
  sar_mode_e                   mode;
  logic [7:0]                  chain_len;
  logic signed [DATA_W-1:0]    sample_code;
  logic signed [DATA_W-1:0]    result;
  logic                        power_up;
  logic                        mode_daisy;
  logic                        eoc;
  logic                        busy;
  logic [DATA_W-1:0]           word;
  logic                        word_valid;
  int                          mismatches;
  int                          num_checks;
  int                          eoc_cnt;
  int                          cycles;

  sar_if link ();

  sar_dev u_sar_dev (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .link        (link.dev),
    .sample_code (sample_code),
    .result      (result),
    .power_up    (power_up),
    .mode_daisy  (mode_daisy),
    .eoc         (eoc)
  );

  sar_host u_sar_host (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .link       (link.host),
    .start      (start),
    .mode       (mode),
    .chain_len  (chain_len),
    .busy       (busy),
    .word       (word),
    .word_valid (word_valid)
  );

  sar_link_monitor u_sar_link_monitor (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .conversion_start_pin    (link.conversion_start_pin),
    .din       (link.din),
    .sclk      (link.sclk),
    .dout_o    (link.dout_o),
    .dout_oe_n (link.dout_oe_n),
    .dout_line (link.dout_line)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock, end-of-conversion count and hang limit
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Sampled off the launching edge so the pulse is read settled
  always @(negedge clk_sys) begin
    cycles++;
    if (eoc === 1'b1) begin
      eoc_cnt++;
    end
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One conversion and read-out; start is held two cycles so the second is refused
  task automatic run(input sar_mode_e m, input logic [7:0] n, input logic [15:0] code);
    int k;
    int w;
    int e0;
    e0 = eoc_cnt;
    sample_code = code;
    mode = m;
    chain_len = n;
    repeat (4) @(negedge clk_sys);
    start = 1'b1;
    repeat (2) @(negedge clk_sys);
    start = 1'b0;
    repeat (20) @(negedge clk_sys);
    check(16'(power_up), 16'h0001, "not powered during conversion");
    for (k = 0; k < int'(n); k++) begin
      w = 0;
      while (word_valid !== 1'b1 && w < 2000) begin
        @(negedge clk_sys);
        w++;
      end
      check(word, (k == 0) ? code : 16'h0000, "read word");
      @(negedge clk_sys);
    end
    w = 0;
    while (busy !== 1'b0 && w < 200) begin
      @(negedge clk_sys);
      w++;
    end
    repeat (3) @(negedge clk_sys);
    check(16'(busy), 16'h0000, "second start taken");
    check(result, code, "stored result");
    check(16'(power_up), 16'h0000, "powered after conversion");
    check(16'(mode_daisy), 16'(m == SAR_MODE_DAISY), "interface option");
    check(16'(eoc_cnt - e0), 16'h0001, "conversion count");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    resetn = 1'b0;
    start = 1'b0;
    mode = SAR_MODE_3W;
    chain_len = 8'h01;
    sample_code = 16'h0000;
    mismatches = 0;
    num_checks = 0;
    eoc_cnt = 0;
    cycles = 0;
    repeat (12) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(16'(link.dout_oe_n), 16'h0001, "data-out driven after reset");
    run(SAR_MODE_3W, 8'h01, 16'h8001);
    run(SAR_MODE_4W, 8'h01, 16'h7ffe);
    run(SAR_MODE_DAISY, 8'h02, 16'ha5c3);
    repeat (6) @(negedge clk_sys);
    check(16'(link.dout_line), 16'h0000, "data-out not low with both pins low");
    wrap_up();
  end

endmodule
